// ==== rtl/timer16_capture_pwm_regs.sv ====
// Sixteen-bit timer with shared byte latch, input capture and phase-correct PWM
`include "timer16_defines.svh"

// How it works
// - High count write stages; low write loads
// - Low count read latches high byte
// - One byte latch shared by all pairs
// - Written count holds, then resumes counting
// - Compare pair loads together, compared continuously
// - Edge copies count, sets capture flag
// - Low capture read latches high byte
// - PWM counts up to top, back down
// - PWM match drives pin per mode
// - PWM compare buffered until top
// - Compare reads return buffered value
// - Compare zero gives fixed level, top too with direct clock
// - Top compare: no pulse or deferred
// - PWM overflow flag at bottom turn
// - Flags request interrupts when enabled
// - Edge select chooses falling or rising
// - PWM select codes off, 8, 9, 10
// - Clock code stops, runs direct or takes prescaled tick
module timer16_capture_pwm_regs (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Host I/O register bus
    input wire timer16_pkg::io_req_t IO_REQ,
    output logic [7:0] IO_RDATA,
    // Control bits and prescaled tick
    input wire timer16_pkg::timer_cfg_t CONFIG,
    input wire logic PRESCALE_TICK,
    // Capture trigger after noise filtering
    input wire logic CAPTURE_INPUT_PIN,
    // Flags and interrupt requests
    input wire timer16_pkg::flag_set_t FLAG_CLEAR,
    input wire timer16_pkg::flag_set_t IRQ_ENABLE,
    input wire logic GLOBAL_IRQ_ENABLE,
    output timer16_pkg::flag_set_t FLAGS,
    output timer16_pkg::flag_set_t IRQ,
    // Compare output pin
    output logic COMPARE_OUTPUT_PIN,
    output logic COMPARE_OUTPUT_ENABLE
);

    // ****************************************
    // Declarations
    // ****************************************
    timer16_pkg::main_state_t st;
    timer16_pkg::main_state_t nx;
    logic tick;
    logic pwm_on;
    logic [15:0] top;
    logic [15:0] cmp_cut;
    logic match;
    logic turn_top;
    logic turn_bottom;
    logic ovf_set;
    logic wr_cnt_hi;
    logic wr_cnt_lo;
    logic wr_cmp_hi;
    logic wr_cmp_lo;
    logic rd_cnt_lo;
    logic rd_cap_lo;
    logic [15:0] cap_value;
    logic cap_flag;
    logic [7:0] cnt_high;
    logic [7:0] cap_high;
    logic [7:0] buf_low;

    // ****************************************
    // Bus decode
    // ****************************************
    assign wr_cnt_hi = IO_REQ.wr && IO_REQ.addr == `CNT_HIGH_ADDR;
    assign wr_cnt_lo = IO_REQ.wr && IO_REQ.addr == `CNT_LOW_ADDR;
    assign wr_cmp_hi = IO_REQ.wr && IO_REQ.addr == `CMP_HIGH_ADDR;
    assign wr_cmp_lo = IO_REQ.wr && IO_REQ.addr == `CMP_LOW_ADDR;
    assign rd_cnt_lo = IO_REQ.rd && IO_REQ.addr == `CNT_LOW_ADDR;
    assign rd_cap_lo = IO_REQ.rd && IO_REQ.addr == `CAP_LOW_ADDR;
    assign cnt_high = st.count[15:8];
    assign cap_high = cap_value[15:8];
    assign buf_low = st.cmp_buf[7:0];

    // ****************************************
    // Timer clock and counting limits
    // ****************************************
    // stop, direct or prescaled clock
    assign tick = (CONFIG.clock_source_select == `CS_STOP) ? 1'b0 :
                  (CONFIG.clock_source_select == `CS_DIRECT) ? 1'b1 : PRESCALE_TICK;
    assign pwm_on = CONFIG.pwm_select != `PWM_OFF;

    always_comb begin
        case (CONFIG.pwm_select)
            `PWM_8BIT: top = `TOP_8BIT;
            `PWM_9BIT: top = `TOP_9BIT;
            `PWM_10BIT: top = `TOP_10BIT;
            default: top = `TOP_FULL;
        endcase
    end

    assign cmp_cut = st.cmp_act & top;
    assign match = tick && st.count == cmp_cut;
    assign turn_top = pwm_on && tick && st.dir == timer16_pkg::COUNT_UP && st.count >= top;
    assign turn_bottom = pwm_on && tick && st.dir == timer16_pkg::COUNT_DOWN
                         && st.count == `WORD_RESET;
    assign ovf_set = pwm_on ? turn_bottom : (tick && !wr_cnt_lo && st.count == `TOP_FULL);

    // ****************************************
    // Capture
    // ****************************************
    capture_unit u_capture (
        .clk(CLK),
        .rst_n(RST_N),
        .pin(CAPTURE_INPUT_PIN),
        .edge_sel(CONFIG.capture_edge_select),
        .flag_clr(FLAG_CLEAR.capture),
        .count(st.count),
        .value(cap_value),
        .flag(cap_flag)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nx = st;

        if (wr_cnt_hi || wr_cmp_hi) begin
            nx.temp = IO_REQ.wdata;
        end else if (rd_cnt_lo) begin
            nx.temp = st.count[15:8];
        end else if (rd_cap_lo) begin
            nx.temp = cap_value[15:8];
        end

        if (wr_cnt_lo) begin
            nx.count = {st.temp, IO_REQ.wdata};
        end else if (tick) begin
            if (!pwm_on) begin
                nx.count = st.count + 16'h0001;
            end else if (turn_top) begin
                nx.count = st.count - 16'h0001;
                nx.dir = timer16_pkg::COUNT_DOWN;
            end else if (turn_bottom) begin
                nx.count = st.count + 16'h0001;
                nx.dir = timer16_pkg::COUNT_UP;
            end else if (st.dir == timer16_pkg::COUNT_UP) begin
                nx.count = st.count + 16'h0001;
            end else begin
                nx.count = st.count - 16'h0001;
            end
        end
        if (!pwm_on) begin
            nx.dir = timer16_pkg::COUNT_UP;
        end

        if (wr_cmp_lo) begin
            nx.cmp_buf = {st.temp, IO_REQ.wdata};
        end
        if (!pwm_on) begin
            nx.cmp_act = nx.cmp_buf;
        end else if (turn_top) begin
            nx.cmp_act = st.cmp_buf;
        end

        if (pwm_on) begin
            nx.oc_en = CONFIG.compare_output_mode[1];
        end else begin
            nx.oc_en = CONFIG.compare_output_mode != `COM_OFF;
        end

        if (pwm_on && match) begin
            if (cmp_cut == `WORD_RESET) begin
                nx.oc_pin = CONFIG.compare_output_mode[0];
            end else if (cmp_cut == top) begin
                if (CONFIG.clock_source_select == `CS_DIRECT) begin
                    nx.oc_pin = ~CONFIG.compare_output_mode[0];
                end else begin
                    nx.oc_pin = ~st.oc_pin;
                end
            end else if (st.dir == timer16_pkg::COUNT_UP) begin
                nx.oc_pin = CONFIG.compare_output_mode[0];
            end else begin
                nx.oc_pin = ~CONFIG.compare_output_mode[0];
            end
        end else if (match) begin
            case (CONFIG.compare_output_mode)
                `COM_TOGGLE: nx.oc_pin = ~st.oc_pin;
                `COM_CLEAR: nx.oc_pin = 1'b0;
                `COM_SET: nx.oc_pin = 1'b1;
                default: nx.oc_pin = st.oc_pin;
            endcase
        end

        // Event flags, a set beats a clear
        nx.ovf_flag = ovf_set | (st.ovf_flag & ~FLAG_CLEAR.overflow);
        nx.cmp_flag = match | (st.cmp_flag & ~FLAG_CLEAR.compare);

        nx.irq.overflow = nx.ovf_flag & IRQ_ENABLE.overflow & GLOBAL_IRQ_ENABLE;
        nx.irq.compare = nx.cmp_flag & IRQ_ENABLE.compare & GLOBAL_IRQ_ENABLE;
        nx.irq.capture = cap_flag & IRQ_ENABLE.capture & GLOBAL_IRQ_ENABLE;

        if (IO_REQ.rd) begin
            if (IO_REQ.addr == `CAP_LOW_ADDR) begin
                nx.rdata = cap_value[7:0];
            end else if (IO_REQ.addr == `CAP_HIGH_ADDR) begin
                nx.rdata = st.temp;
            end else if (IO_REQ.addr == `CMP_LOW_ADDR) begin
                nx.rdata = st.cmp_buf[7:0];
            end else if (IO_REQ.addr == `CMP_HIGH_ADDR) begin
                nx.rdata = st.cmp_buf[15:8];
            end else if (IO_REQ.addr == `CNT_LOW_ADDR) begin
                nx.rdata = st.count[7:0];
            end else if (IO_REQ.addr == `CNT_HIGH_ADDR) begin
                nx.rdata = st.temp;
            end else begin
                nx.rdata = `BYTE_RESET;
            end
        end
    end

    // ****************************************
    // State register and outputs
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign IO_RDATA = st.rdata;
    assign FLAGS.overflow = st.ovf_flag;
    assign FLAGS.compare = st.cmp_flag;
    assign FLAGS.capture = cap_flag;
    assign IRQ = st.irq;
    assign COMPARE_OUTPUT_PIN = st.oc_pin;
    assign COMPARE_OUTPUT_ENABLE = st.oc_en;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // Host leaves one idle cycle between the two bytes of a word
    sequence seq_idle;
        !IO_REQ.wr && !IO_REQ.rd;
    endsequence
    sequence seq_cnt_pair;
        wr_cnt_hi ##1 seq_idle ##1 wr_cnt_lo;
    endsequence
    sequence seq_cnt_read;
        rd_cnt_lo ##1 seq_idle ##1 (IO_REQ.rd && IO_REQ.addr == `CNT_HIGH_ADDR);
    endsequence
    sequence seq_cap_read;
        rd_cap_lo ##1 seq_idle ##1 (IO_REQ.rd && IO_REQ.addr == `CAP_HIGH_ADDR);
    endsequence
    sequence seq_cmp_pair;
        wr_cmp_hi ##1 seq_idle ##1 wr_cmp_lo;
    endsequence

    AST_CNT_PAIR_LOAD: assert property (seq_cnt_pair |=>
        st.count == {$past(IO_REQ.wdata, 3), $past(IO_REQ.wdata)})
        else $error("counter pair write did not load both bytes");
    AST_CNT_READ_LATCH: assert property (seq_cnt_read |=>
        st.rdata == $past(cnt_high, 3))
        else $error("counter high read did not return latched byte");
    AST_LATCH_SHARED: assert property (wr_cmp_hi |=> st.temp == $past(IO_REQ.wdata))
        else $error("compare high write did not stage in latch");
    AST_RESUME_COUNT: assert property (wr_cnt_lo ##1 (!IO_REQ.wr && tick && !pwm_on)
        |=> st.count == $past(st.count) + 16'h0001)
        else $error("counter did not resume after write");
    AST_CMP_PAIR_LOAD: assert property (seq_cmp_pair |=>
        st.cmp_buf == {$past(IO_REQ.wdata, 3), $past(IO_REQ.wdata)})
        else $error("compare pair write did not load both bytes");
    AST_CAP_READ_LATCH: assert property (seq_cap_read |=>
        st.rdata == $past(cap_high, 3))
        else $error("capture high read did not return latched byte");
    AST_TURN_AT_TOP: assert property (turn_top && !wr_cnt_lo |=>
        st.dir == timer16_pkg::COUNT_DOWN && st.count == $past(st.count) - 16'h0001)
        else $error("counter did not turn down at top");
    AST_PWM_UP_CLEAR: assert property (pwm_on && match && st.dir == timer16_pkg::COUNT_UP
        && CONFIG.compare_output_mode[1] && cmp_cut != `WORD_RESET
        && cmp_cut != top |=> st.oc_pin == $past(CONFIG.compare_output_mode[0]))
        else $error("up match gave wrong pin level");
    AST_BUF_HOLD: assert property (pwm_on && !turn_top |=> $stable(st.cmp_act))
        else $error("active compare changed away from top");
    AST_READ_BUF: assert property (IO_REQ.rd && IO_REQ.addr == `CMP_LOW_ADDR
        |=> st.rdata == $past(buf_low))
        else $error("compare read did not return buffered value");
    AST_OVF_AT_BOTTOM: assert property (turn_bottom |=> st.ovf_flag)
        else $error("overflow flag missed at bottom turn");
    AST_OVF_IRQ: assert property (IRQ_ENABLE.overflow && GLOBAL_IRQ_ENABLE
        |=> st.irq.overflow == st.ovf_flag)
        else $error("overflow request does not follow its flag");
    AST_CMP_IRQ: assert property (IRQ_ENABLE.compare && GLOBAL_IRQ_ENABLE
        |=> st.irq.compare == st.cmp_flag)
        else $error("compare request does not follow its flag");
    AST_STOPPED: assert property (CONFIG.clock_source_select == `CS_STOP && !wr_cnt_lo
        |=> $stable(st.count))
        else $error("stopped counter moved");
    AST_CAP_WRITE_IGNORED: assert property (IO_REQ.wr && !IO_REQ.rd
        && (IO_REQ.addr == `CAP_LOW_ADDR || IO_REQ.addr == `CAP_HIGH_ADDR)
        |=> $stable(st.temp))
        else $error("capture write disturbed the latch");
    AST_WRAP_UP: assert property (!pwm_on && tick && !wr_cnt_lo
        |=> st.count == $past(st.count) + 16'h0001)
        else $error("normal count did not step up");
    AST_CMP_FLAG: assert property (match |=> st.cmp_flag)
        else $error("compare flag missed on match");
    AST_OC_ENABLE: assert property (pwm_on
        |=> st.oc_en == $past(CONFIG.compare_output_mode[1]))
        else $error("pin enable wrong in pwm mode");
    AST_BUF_TURN: assert property (turn_top |=> st.cmp_act == $past(st.cmp_buf))
        else $error("buffered compare not taken at top");
    AST_ZERO_LEVEL: assert property (pwm_on && match && cmp_cut == `WORD_RESET
        |=> st.oc_pin == $past(CONFIG.compare_output_mode[0]))
        else $error("zero compare gave wrong level");
    AST_TOP_DIRECT: assert property (pwm_on && match && cmp_cut == top
        && CONFIG.clock_source_select == `CS_DIRECT
        |=> st.oc_pin != $past(CONFIG.compare_output_mode[0]))
        else $error("top compare gave a pulse");

endmodule // timer16_capture_pwm_regs

// ==== rtl/timer16_defines.svh ====
// Register offsets, field codes, reset values and limits of the 16-bit timer
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

// ****************************************
// Register offsets on the I/O bus
// ****************************************
`define CAP_LOW_ADDR 6'h26
`define CAP_HIGH_ADDR 6'h27
`define CMP_LOW_ADDR 6'h2a
`define CMP_HIGH_ADDR 6'h2b
`define CNT_LOW_ADDR 6'h2c
`define CNT_HIGH_ADDR 6'h2d

// ****************************************
// Field codes
// ****************************************
`define CS_STOP 3'h0
`define CS_DIRECT 3'h1
`define PWM_OFF 2'h0
`define PWM_8BIT 2'h1
`define PWM_9BIT 2'h2
`define PWM_10BIT 2'h3
`define COM_OFF 2'h0
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3

// ****************************************
// Reset values and counter limits
// ****************************************
`define WORD_RESET 16'h0000
`define BYTE_RESET 8'h00
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff
`define TOP_FULL 16'hffff

`endif

// ==== rtl/timer16_pkg.sv ====
// Types shared by the 16-bit timer modules
package timer16_pkg;

    // Host bus request, one access per cycle
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } io_req_t;

    // Control bits decoded outside the block
    typedef struct packed {
        logic [2:0] clock_source_select;
        logic [1:0] pwm_select;
        logic [1:0] compare_output_mode;
        logic capture_edge_select;
    } timer_cfg_t;

    // One bit per timer event
    typedef struct packed {
        logic overflow;
        logic compare;
        logic capture;
    } flag_set_t;

    typedef enum logic {COUNT_UP, COUNT_DOWN} dir_t;

    typedef struct packed {
        logic [15:0] count;
        logic [7:0] temp;
        logic [15:0] cmp_buf;
        logic [15:0] cmp_act;
        dir_t dir;
        logic oc_pin;
        logic oc_en;
        logic [7:0] rdata;
        logic ovf_flag;
        logic cmp_flag;
        flag_set_t irq;
    } main_state_t;

    typedef struct packed {
        logic prev;
        logic [15:0] value;
        logic flag;
    } capture_state_t;

endpackage

// ==== rtl/capture_unit.sv ====
// Edge-triggered capture of the count into a read-only word
`include "timer16_defines.svh"

module capture_unit (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Trigger
    input wire logic pin,
    input wire logic edge_sel,
    input wire logic flag_clr,
    input wire logic [15:0] count,
    // Captured word and flag
    output logic [15:0] value,
    output logic flag
);

    timer16_pkg::capture_state_t st_reg;
    timer16_pkg::capture_state_t st_next;
    logic edge_seen;

    assign edge_seen = edge_sel ? (pin & ~st_reg.prev) : (~pin & st_reg.prev);

    always_comb begin
        st_next = st_reg;
        st_next.prev = pin;
        if (edge_seen) begin
            st_next.value = count;
        end
        st_next.flag = edge_seen | (st_reg.flag & ~flag_clr);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign value = st_reg.value;
    assign flag = st_reg.flag;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_CAPTURE_TAKE: assert property (edge_seen |=> flag && value == $past(count))
        else $error("capture did not take count and flag");
    AST_EDGE_SELECT: assert property (!edge_sel && pin |=> !edge_seen || !pin)
        else $error("capture fired on wrong edge");

endmodule // capture_unit

// ==== sim/io_host_model.sv ====
// Host CPU model that drives the timer's byte-wide I/O register bus
module io_host_model (
    // Clock
    input wire logic clk,
    // I/O register bus
    output timer16_pkg::io_req_t req,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        req = {6'h00, 8'h00, 1'h0, 1'h0};
    end

    // ****************************************
    // Byte accesses: strobe cycle, then idle cycle
    // ****************************************
    task automatic write_byte(input logic [5:0] addr, input logic [7:0] data);
        @(negedge clk);
        req.addr = addr;
        req.wdata = data;
        req.wr = 1'h1;
        @(negedge clk);
        req.wr = 1'h0;
        req.wdata = ~data;
    endtask

    task automatic read_byte(input logic [5:0] addr, output logic [7:0] data);
        @(negedge clk);
        req.addr = addr;
        req.rd = 1'h1;
        @(negedge clk);
        data = rdata;
        req.rd = 1'h0;
    endtask

    // ****************************************
    // Word accesses through the shared latch
    // ****************************************
    // high byte written first
    task automatic write_word(input logic [5:0] addr_hi, input logic [15:0] data);
        write_byte(addr_hi, data[15:8]);
        write_byte(addr_hi - 6'h01, data[7:0]);
    endtask

    task automatic read_word(input logic [5:0] addr_lo, output logic [15:0] data);
        read_byte(addr_lo, data[7:0]);
        read_byte(addr_lo + 6'h01, data[15:8]);
    endtask
endmodule // io_host_model

// ==== sim/timer16_capture_pwm_regs_tb_top.sv ====
// Self-checking testbench of the 16-bit timer with capture and PWM
module timer16_capture_pwm_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'h0;
    logic rst_n = 1'h0;
    timer16_pkg::io_req_t io_req;
    logic [7:0] io_rdata;
    timer16_pkg::timer_cfg_t cfg = 8'h00;
    logic tick = 1'h0;
    logic cap_pin = 1'h0;
    timer16_pkg::flag_set_t flag_clr = 3'h0;
    timer16_pkg::flag_set_t irq_en = 3'h0;
    logic gie = 1'h0;
    timer16_pkg::flag_set_t flags;
    timer16_pkg::flag_set_t irq;
    logic oc_pin;
    logic oc_en;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0 = 0;

    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    timer16_capture_pwm_regs i_dut (
        .CLK(clk), .RST_N(rst_n), .IO_REQ(io_req), .IO_RDATA(io_rdata),
        .CONFIG(cfg), .PRESCALE_TICK(tick), .CAPTURE_INPUT_PIN(cap_pin),
        .FLAG_CLEAR(flag_clr), .IRQ_ENABLE(irq_en), .GLOBAL_IRQ_ENABLE(gie),
        .FLAGS(flags), .IRQ(irq), .COMPARE_OUTPUT_PIN(oc_pin),
        .COMPARE_OUTPUT_ENABLE(oc_en)
    );

    io_host_model i_host (.clk(clk), .req(io_req), .rdata(io_rdata));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic set_cfg(input logic [2:0] cs, input logic [1:0] pwm, input logic [1:0] com,
                           input logic es);
        @(negedge clk);
        cfg = {cs, pwm, com, es};
    endtask

    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'h0;
        repeat (2) @(negedge clk);
        rst_n = 1'h1;
    endtask

    task automatic wait_cyc(input int n);
        while (cyc - t0 < n) @(negedge clk);
    endtask

    task automatic pulse_clear(input timer16_pkg::flag_set_t f);
        @(negedge clk);
        flag_clr = f;
        @(negedge clk);
        flag_clr = 3'h0;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        logic [15:0] rd;
        logic [5:0] lo_addr [3] = '{6'h26, 6'h2a, 6'h2c};
        int top;
        repeat (16) @(negedge clk);
        rst_n = 1'h1;

        foreach (lo_addr[i]) begin
            i_host.read_word(lo_addr[i], rd);
            check("reset value", rd, 16'h0000);
        end
        i_host.read_byte(6'h28, rd[7:0]);
        check("unmapped read", {8'h00, rd[7:0]}, 16'h0000);
        $display("Test reset values done");

        i_host.write_word(6'h2d, 16'h1234);
        i_host.read_word(6'h2c, rd);
        check("count word", rd, 16'h1234);
        i_host.write_byte(6'h2b, 8'h5a);
        i_host.write_byte(6'h2c, 8'h78);
        i_host.read_word(6'h2c, rd);
        check("latch from compare", rd, 16'h5a78);
        i_host.read_byte(6'h2c, rd[7:0]);
        i_host.write_byte(6'h2b, 8'h11);
        i_host.read_byte(6'h2d, rd[15:8]);
        check("high read from latch", {8'h00, rd[15:8]}, 16'h0011);
        i_host.write_byte(6'h2d, 8'h9c);
        i_host.write_byte(6'h27, 8'hee);
        i_host.write_byte(6'h26, 8'hdd);
        i_host.write_byte(6'h2c, 8'h01);
        i_host.read_word(6'h2c, rd);
        check("latch after capture write", rd, 16'h9c01);
        i_host.read_word(6'h26, rd);
        check("capture after write", rd, 16'h0000);
        i_host.write_word(6'h2b, 16'habcd);
        i_host.read_word(6'h2a, rd);
        check("compare word", rd, 16'habcd);
        $display("Test shared latch done");

        irq_en = 3'h6;
        set_cfg(3'h1, 2'h0, 2'h0, 1'h0);
        i_host.write_word(6'h2d, 16'hfffe);
        set_cfg(3'h2, 2'h0, 2'h0, 1'h0);
        repeat (2) begin
            @(negedge clk);
            tick = 1'h1;
            @(negedge clk);
            tick = 1'h0;
        end
        set_cfg(3'h0, 2'h0, 2'h0, 1'h0);
        i_host.read_word(6'h2c, rd);
        check("count after wrap", rd, 16'h0001);
        check("overflow flag", 16'(flags.overflow), 16'h0001);
        check("masked request", 16'(irq.overflow), 16'h0000);
        @(negedge clk);
        gie = 1'h1;
        repeat (2) @(negedge clk);
        check("overflow request", 16'(irq.overflow), 16'h0001);
        pulse_clear(3'h4);
        @(negedge clk);
        check("overflow cleared", 16'(flags.overflow), 16'h0000);
        $display("Test normal counting done");

        set_cfg(3'h0, 2'h0, 2'h0, 1'h1);
        i_host.write_word(6'h2d, 16'h0a5c);
        @(negedge clk);
        cap_pin = 1'h1;
        repeat (2) @(negedge clk);
        check("capture flag", 16'(flags.capture), 16'h0001);
        i_host.read_word(6'h26, rd);
        check("capture rising", rd, 16'h0a5c);
        pulse_clear(3'h1);
        set_cfg(3'h0, 2'h0, 2'h0, 1'h0);
        i_host.write_word(6'h2d, 16'hc3e1);
        @(negedge clk);
        cap_pin = 1'h0;
        repeat (2) @(negedge clk);
        i_host.read_word(6'h26, rd);
        check("capture falling", rd, 16'hc3e1);
        $display("Test capture done");

        do_reset();
        i_host.write_word(6'h2b, 16'h0080);
        set_cfg(3'h1, 2'h1, 2'h3, 1'h0);
        t0 = cyc;
        wait_cyc(20);
        check("pin enable", 16'(oc_en), 16'h0001);
        i_host.write_word(6'h2b, 16'h0040);
        i_host.read_word(6'h2a, rd);
        check("buffered readback", rd, 16'h0040);
        wait_cyc(100);
        check("pin before old match", 16'(oc_pin), 16'h0000);
        wait_cyc(200);
        check("pin up match", 16'(oc_pin), 16'h0001);
        check("compare flag", 16'(flags.compare), 16'h0001);
        check("pwm compare request", 16'(irq.compare), 16'h0001);
        wait_cyc(420);
        check("pin before new match", 16'(oc_pin), 16'h0001);
        wait_cyc(460);
        check("pin down match", 16'(oc_pin), 16'h0000);
        wait_cyc(510);
        check("no early overflow", 16'(flags.overflow), 16'h0000);
        wait_cyc(511);
        check("overflow at bottom", 16'(flags.overflow), 16'h0001);
        wait_cyc(512);
        check("pwm overflow request", 16'(irq.overflow), 16'h0001);
        $display("Test 8-bit PWM done");

        set_cfg(3'h0, 2'h0, 2'h2, 1'h0);
        do_reset();
        i_host.write_word(6'h2b, 16'h00ff);
        set_cfg(3'h1, 2'h1, 2'h2, 1'h0);
        t0 = cyc;
        wait_cyc(200);
        check("pin before top match", 16'(oc_pin), 16'h0000);
        wait_cyc(300);
        check("top compare level", 16'(oc_pin), 16'h0001);
        $display("Test top compare done");

        for (int code = 2; code <= 3; code++) begin
            top = (1 << (code + 7)) - 1;
            set_cfg(3'h1, code[1:0], 2'h3, 1'h0);
            do_reset();
            t0 = cyc;
            while (flags.overflow !== 1'h1 && cyc - t0 < 4000) @(negedge clk);
            check("pwm period", 16'(cyc - t0), 16'(2 * top + 1));
            check("zero compare level", 16'(oc_pin), 16'h0001);
        end
        $display("Test 9 and 10-bit PWM done");
        give_verdict();
    end

    initial begin
        #1000000;
        n_fail++;
        $display("Watchdog expired before the tests ended");
        give_verdict();
    end
endmodule // timer16_capture_pwm_regs_tb_top
